//--- hw/pbd_decoder.sv
`timescale 1ns/10ps
// Byte-wide instruction decoder: prefixes, primary and secondary dispatch,
// illegal-code trapping and nominal cycle accounting with memory stalls.
module pbd_decoder
  import pbd_pkg::*;
(
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Instruction fetch unit.
  input  wire logic         fetch_valid,
  input  wire logic [7:0]   fetch_byte,
  output logic              fetch_ready,
  output logic              flow_change,
  input  wire logic         fetch_refilled,
  // Memory interface state.
  input  wire logic         mem_issue,
  input  wire logic         mem_done,
  input  wire logic         mem_other_busy,
  input  wire logic         read_data_pending,
  // Operation data from the execution side.
  input  wire logic         branch_zero,
  input  wire logic [5:0]   var_cycles,
  input  wire logic         trap_enabled,
  input  wire logic         trap_raised,
  // Dispatch to the register stack and execution units.
  output logic              dispatch,
  output pbd_pkg::pbd_fn_t  prim_fn,
  output logic              secondary,
  output logic [31:0]       operand_out,
  output logic [7:0]        feature_tags,
  output logic              busy,
  output logic              done,
  output logic              free_ram_push,
  // Trap handler.
  output logic              illegal,
  output logic [3:0]        err_code
);
  import pbd_pkg::*;

  // ****************************************************************
  // Local declarations.
  // ****************************************************************
  pbd_state_t  state_reg;
  pbd_state_t  state_next;
  logic        take;
  logic [31:0] operand;
  logic        is_prefix;
  pbd_fn_t     fn;
  logic        legal;
  logic [5:0]  cycles;
  logic [7:0]  tags;
  logic        jumps;
  logic        mem_use;
  logic        mem_use_reg;
  logic [1:0]  outstanding_reg;
  logic        mem_stall;
  logic        ctr_last;
  logic        flow_reg;

  // Secondary code lookup: legal flag, nominal cycles, feature tags.
  function automatic logic [14:0] sec_lookup(input logic [31:0] op, input logic [5:0] vc);
    logic [14:0] r;
    r = {1'b0, PBD_CYC_ONE, PBD_TAGS_NONE};
    case (op)
      PBD_OP_SAVEH, PBD_OP_SAVEL:      r = {1'b1, PBD_CYC_THREE, PBD_TAGS_NONE};
      PBD_OP_STHF, PBD_OP_STHB:        r = {1'b1, PBD_CYC_ONE, PBD_TAGS_NONE};
      PBD_OP_STLF, PBD_OP_STLB:        r = {1'b1, PBD_CYC_ONE, PBD_TAGS_NONE};
      PBD_OP_FREERAM:                  r = {1'b1, PBD_CYC_ONE, PBD_TAGS_NONE};
      PBD_OP_TESTPRANAL, PBD_OP_DEVID: r = {1'b1, PBD_CYC_ONE, PBD_TAGS_NONE};
      PBD_OP_STTIMER:                  r = {1'b1, PBD_CYC_TWO, PBD_TAGS_NONE};
      PBD_OP_AND, PBD_OP_OR, PBD_OP_XOR, PBD_OP_NOT,
      PBD_OP_SHL, PBD_OP_SHR, PBD_OP_DIFF, PBD_OP_SUM:
                                       r = {1'b1, PBD_CYC_ONE, PBD_TAGS_NONE};
      PBD_OP_ADD, PBD_OP_SUB:          r = {1'b1, PBD_CYC_TWO, PBD_TAGS_AO};
      PBD_OP_MUL:                      r = {1'b1, PBD_CYC_THREE, PBD_TAGS_AO};
      PBD_OP_FMUL:                     r = {1'b1, PBD_CYC_FIVE, PBD_TAGS_AO};
      PBD_OP_GT, PBD_OP_GTU:           r = {1'b1, PBD_CYC_TWO, PBD_TAGS_A};
      PBD_OP_PROD:                     r = {1'b1, PBD_CYC_THREE, PBD_TAGS_A};
      PBD_OP_SATADD, PBD_OP_SATSUB:    r = {1'b1, PBD_CYC_TWO, PBD_TAGS_A};
      PBD_OP_SATMUL:                   r = {1'b1, PBD_CYC_FOUR, PBD_TAGS_A};
      // Divide and remainder length is supplied by the divider, clamped to range.
      PBD_OP_DIV, PBD_OP_REM: begin
        r = {1'b1, (vc > PBD_CYC_DMAX) ? PBD_CYC_DMAX :
                   (vc < PBD_CYC_THREE) ? PBD_CYC_THREE : vc, PBD_TAGS_AO};
      end
      default:                         r = {1'b0, PBD_CYC_ONE, PBD_TAGS_NONE};
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Operand accumulation and counting.
  // ****************************************************************
  pbd_opnd u_opnd (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .take       (take),
    .instr_byte (fetch_byte),
    .operand    (operand),
    .is_prefix  (is_prefix)
  );

  pbd_cycctr u_cycctr (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (take),
    .count    (cycles),
    .hold     (mem_stall),
    .last     (ctr_last)
  );

  // A byte is accepted only when idle; stall term blocks dependent reads.
  assign fetch_ready = (state_reg == PBD_ST_IDLE) && !read_data_pending;
  assign take        = fetch_valid && fetch_ready;
  assign fn          = pbd_fn_t'(fetch_byte[PBD_FN_MSB:PBD_FN_LSB]);

  // Primary dispatch: legal flag, cycles, tags and flow change per byte.
  always_comb begin
    logic [14:0] s;
    s       = sec_lookup(operand, var_cycles);
    legal   = 1'b1;
    cycles  = PBD_CYC_ONE;
    tags    = PBD_TAGS_NONE;
    jumps   = 1'b0;
    mem_use = 1'b0;
    case (fn)
      PBD_FN_JUMP: begin
        cycles = PBD_CYC_JUMP;
        tags   = PBD_TAGS_DT;
        jumps  = 1'b1;
      end
      PBD_FN_CALL: begin
        cycles = PBD_CYC_CALL;
        jumps  = 1'b1;
      end
      PBD_FN_BRZ: begin
        cycles = branch_zero ? PBD_CYC_JUMP : PBD_CYC_ONE;
        jumps  = branch_zero;
      end
      PBD_FN_PFIX, PBD_FN_NFIX: cycles = PBD_CYC_ZERO;
      PBD_FN_ADC: begin
        cycles = PBD_CYC_TWO;
        tags   = PBD_TAGS_O;
      end
      PBD_FN_AJW:  cycles = PBD_CYC_TWO;
      // Plain loads and stores carry no trap tags of their own.
      PBD_FN_STNL: begin
        cycles  = PBD_CYC_TWO;
        mem_use = 1'b1;
      end
      PBD_FN_LDNL, PBD_FN_LDL, PBD_FN_STL: mem_use = 1'b1;
      PBD_FN_OPERATE: begin
        legal  = s[14];
        cycles = s[13:8];
        tags   = s[7:0];
      end
      default: cycles = PBD_CYC_ONE;
    endcase
  end

  // ****************************************************************
  // Memory tracking and stalls.
  // ****************************************************************
  // Two operations may be in flight; a third or contended access stalls only the two-cycle STNL, as one-cycle loads and stores never reach EXEC.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      outstanding_reg <= 2'h0;
    end else if (mem_issue && !mem_done) begin
      outstanding_reg <= outstanding_reg + 2'h1;
    end else if (mem_done && !mem_issue && outstanding_reg != 2'h0) begin
      outstanding_reg <= outstanding_reg - 2'h1;
    end
  end

  assign mem_stall = (state_reg == PBD_ST_EXEC) && mem_use_reg &&
                     ((outstanding_reg == PBD_MEM_MAX) || mem_other_busy);

  // Memory use of the running instruction, kept for the stall test.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mem_use_reg <= 1'b0;
    end else if (take) begin
      mem_use_reg <= mem_use;
    end
  end

  // ****************************************************************
  // Sequencing.
  // ****************************************************************
  // Traps end the instruction early, so nominal counts no longer apply.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PBD_ST_IDLE: begin
        if (take && !is_prefix && legal && cycles != PBD_CYC_ONE) begin
          state_next = PBD_ST_EXEC;
        end else if (take && jumps) begin
          state_next = PBD_ST_REFL;
        end
      end
      PBD_ST_EXEC: begin
        if (trap_raised) begin
          state_next = PBD_ST_IDLE;
        end else if (ctr_last) begin
          state_next = flow_reg ? PBD_ST_REFL : PBD_ST_IDLE;
        end
      end
      PBD_ST_REFL: begin
        if (fetch_refilled) begin
          state_next = PBD_ST_IDLE;
        end
      end
      default: state_next = PBD_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= PBD_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Remember whether the running instruction changes control flow.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flow_reg <= 1'b0;
    end else if (take) begin
      flow_reg <= jumps;
    end
  end

  assign flow_change = (state_reg == PBD_ST_REFL);
  assign busy        = (state_reg != PBD_ST_IDLE);
  assign done        = ((state_reg == PBD_ST_EXEC) && ctr_last && !trap_raised) ||
                       ((state_reg == PBD_ST_IDLE) && take && !is_prefix && legal &&
                        cycles == PBD_CYC_ONE);

  // ****************************************************************
  // Registered dispatch outputs.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dispatch      <= 1'b0;
      prim_fn       <= PBD_FN_JUMP;
      secondary     <= 1'b0;
      operand_out   <= PBD_OPND_RST;
      feature_tags  <= PBD_TAGS_NONE;
      free_ram_push <= 1'b0;
    end else begin
      dispatch      <= take && !is_prefix && legal;
      free_ram_push <= take && fn == PBD_FN_OPERATE && operand == PBD_OP_FREERAM;
      if (take && !is_prefix) begin
        prim_fn      <= fn;
        secondary    <= (fn == PBD_FN_OPERATE);
        operand_out  <= operand;
        feature_tags <= tags;
      end
    end
  end

  // Illegal codes pulse only when the trap handler can take them.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      illegal  <= 1'b0;
      err_code <= 4'h0;
    end else begin
      illegal  <= take && !legal && trap_enabled;
      err_code <= (take && !legal && trap_enabled) ? PBD_ERR_ILLEGAL : 4'h0;
    end
  end

endmodule

//--- hw/pbd_pkg.sv
// Behaviour
// - Each instruction byte: high nibble is function code, low nibble is data.
// - Operands below sixteen need one byte and no prefix.
// - Each positive prefix adds one more four-bit operand group.
// - A leading negative prefix yields a sign-extended 32-bit operand.
// - Function codes 0 to F map to the sixteen primary operations.
// - Operate uses the accumulated operand to pick a secondary operation.
// - Unknown operation codes are flagged illegal and trapped if enabled.
// - Nominal counts assume two-cycle internal memory without contention.
// - Jump 7, call 8, branch_if_zero 1 or 7, prefixes 0 cycles.
// - Divide and remainder take data-dependent cycle counts within ranges.
// - Stall while a needed stack value awaits the previous final read.
// - At most two memory operations outstanding; a third waits (only STNL stalls here; LDNL, LDL and STL do not).
// - Data memory operations yield to fetch and subsystem memory use (only STNL stalls on mem_other_busy here).
// - After a control-flow change wait for the fetch unit to refill.
// - Cycle counts hold only when the instruction completes without trap.
// - E, L, S, O tags mark fault, read-watch, write-watch, overflow traps.
// - A, I, D, T tags mark abortable, interruptible, deschedule, timeslice.
// - Queue register saves for high and low priority take three cycles.
// - High-priority queue front and back pointer stores take one cycle.
// - Low-priority queue front and back pointer stores take one cycle.
// - Push of free_ram_base takes a single cycle.
package pbd_pkg;

  // ****************************************************************
  // Instruction format.
  // ****************************************************************
  localparam int unsigned PBD_FN_MSB  = 7;
  localparam int unsigned PBD_FN_LSB  = 4;
  localparam int unsigned PBD_DAT_MSB = 3;
  localparam int unsigned PBD_NIB_W   = 4;
  localparam logic [31:0] PBD_OPND_RST = 32'h0000_0000;

  // ****************************************************************
  // Primary function codes.
  // ****************************************************************
  typedef enum logic [3:0] {
    PBD_FN_JUMP    = 4'h0,
    PBD_FN_LDLP    = 4'h1,
    PBD_FN_PFIX    = 4'h2,
    PBD_FN_LDNL    = 4'h3,
    PBD_FN_LDC     = 4'h4,
    PBD_FN_LDNLP   = 4'h5,
    PBD_FN_NFIX    = 4'h6,
    PBD_FN_LDL     = 4'h7,
    PBD_FN_ADC     = 4'h8,
    PBD_FN_CALL    = 4'h9,
    PBD_FN_BRZ     = 4'ha,
    PBD_FN_AJW     = 4'hb,
    PBD_FN_EQC     = 4'hc,
    PBD_FN_STL     = 4'hd,
    PBD_FN_STNL    = 4'he,
    PBD_FN_OPERATE = 4'hf
  } pbd_fn_t;

  // ****************************************************************
  // Secondary operation codes (operand value after prefixing).
  // ****************************************************************
  localparam logic [31:0] PBD_OP_TESTPRANAL = 32'h0000_002a;
  localparam logic [31:0] PBD_OP_SAVEH      = 32'h0000_003e;
  localparam logic [31:0] PBD_OP_SAVEL      = 32'h0000_003d;
  localparam logic [31:0] PBD_OP_STHF       = 32'h0000_0018;
  localparam logic [31:0] PBD_OP_STHB       = 32'h0000_0050;
  localparam logic [31:0] PBD_OP_STLF       = 32'h0000_001c;
  localparam logic [31:0] PBD_OP_STLB       = 32'h0000_0017;
  localparam logic [31:0] PBD_OP_STTIMER    = 32'h0000_0054;
  localparam logic [31:0] PBD_OP_DEVID      = 32'h0000_017c;
  localparam logic [31:0] PBD_OP_FREERAM    = 32'h0000_007e;
  localparam logic [31:0] PBD_OP_AND        = 32'h0000_0046;
  localparam logic [31:0] PBD_OP_OR         = 32'h0000_004b;
  localparam logic [31:0] PBD_OP_XOR        = 32'h0000_0033;
  localparam logic [31:0] PBD_OP_NOT        = 32'h0000_0032;
  localparam logic [31:0] PBD_OP_SHL        = 32'h0000_0041;
  localparam logic [31:0] PBD_OP_SHR        = 32'h0000_0040;
  localparam logic [31:0] PBD_OP_ADD        = 32'h0000_0005;
  localparam logic [31:0] PBD_OP_SUB        = 32'h0000_000c;
  localparam logic [31:0] PBD_OP_MUL        = 32'h0000_0053;
  localparam logic [31:0] PBD_OP_FMUL       = 32'h0000_0072;
  localparam logic [31:0] PBD_OP_DIV        = 32'h0000_002c;
  localparam logic [31:0] PBD_OP_REM        = 32'h0000_001f;
  localparam logic [31:0] PBD_OP_GT         = 32'h0000_0009;
  localparam logic [31:0] PBD_OP_GTU        = 32'h0000_005f;
  localparam logic [31:0] PBD_OP_DIFF       = 32'h0000_0004;
  localparam logic [31:0] PBD_OP_SUM        = 32'h0000_0052;
  localparam logic [31:0] PBD_OP_PROD       = 32'h0000_0008;
  localparam logic [31:0] PBD_OP_SATADD     = 32'h0000_0068;
  localparam logic [31:0] PBD_OP_SATSUB     = 32'h0000_0069;
  localparam logic [31:0] PBD_OP_SATMUL     = 32'h0000_006a;

  // ****************************************************************
  // Cycle counts and feature tags.
  // ****************************************************************
  localparam logic [5:0] PBD_CYC_ZERO  = 6'h00;
  localparam logic [5:0] PBD_CYC_ONE   = 6'h01;
  localparam logic [5:0] PBD_CYC_TWO   = 6'h02;
  localparam logic [5:0] PBD_CYC_THREE = 6'h03;
  localparam logic [5:0] PBD_CYC_FOUR  = 6'h04;
  localparam logic [5:0] PBD_CYC_FIVE  = 6'h05;
  localparam logic [5:0] PBD_CYC_JUMP  = 6'h07;
  localparam logic [5:0] PBD_CYC_CALL  = 6'h08;
  localparam logic [5:0] PBD_CYC_DMAX  = 6'h23;
  localparam logic [1:0] PBD_MEM_MAX   = 2'h2;

  // Feature tag bit positions: E L S O I A D T.
  localparam int unsigned PBD_TAG_E = 0;
  localparam int unsigned PBD_TAG_L = 1;
  localparam int unsigned PBD_TAG_S = 2;
  localparam int unsigned PBD_TAG_O = 3;
  localparam int unsigned PBD_TAG_I = 4;
  localparam int unsigned PBD_TAG_A = 5;
  localparam int unsigned PBD_TAG_D = 6;
  localparam int unsigned PBD_TAG_T = 7;
  localparam logic [7:0]  PBD_TAGS_NONE = 8'h00;
  localparam logic [7:0]  PBD_TAGS_AO   = 8'h28;
  localparam logic [7:0]  PBD_TAGS_A    = 8'h20;
  localparam logic [7:0]  PBD_TAGS_DT   = 8'hc0;
  localparam logic [7:0]  PBD_TAGS_O    = 8'h08;
  localparam logic [7:0]  PBD_TAGS_LS   = 8'h06;

  // Illegal-instruction error code handed to the trap logic; value arbitrary.
  localparam logic [3:0] PBD_ERR_ILLEGAL = 4'h1;

  // ****************************************************************
  // Execution states.
  // ****************************************************************
  typedef enum logic [1:0] {
    PBD_ST_IDLE = 2'b00,
    PBD_ST_EXEC = 2'b01,
    PBD_ST_REFL = 2'b10
  } pbd_state_t;

endpackage

//--- hw/pbd_opnd.sv
`timescale 1ns/10ps
// Operand accumulator for prefixed instructions.
module pbd_opnd
  import pbd_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Byte accepted this cycle.
  input  wire logic        take,
  input  wire logic [7:0]  instr_byte,
  // Operand seen by the instruction that takes this byte.
  output logic      [31:0] operand,
  output logic             is_prefix
);
  import pbd_pkg::*;

  logic [31:0] opnd_reg;
  logic [3:0]  fn;

  // Nibble merge happens combinationally so the final byte sees it at once.
  assign fn        = instr_byte[PBD_FN_MSB:PBD_FN_LSB];
  assign operand   = opnd_reg | {28'h0000000, instr_byte[PBD_DAT_MSB:0]};
  assign is_prefix = (fn == PBD_FN_PFIX) || (fn == PBD_FN_NFIX);

  // Prefix shifts, negative prefix inverts first; anything else clears.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      opnd_reg <= PBD_OPND_RST;
    end else if (take) begin
      if (fn == PBD_FN_PFIX) begin
        opnd_reg <= operand << PBD_NIB_W;
      end else if (fn == PBD_FN_NFIX) begin
        opnd_reg <= (~operand) << PBD_NIB_W;
      end else begin
        opnd_reg <= PBD_OPND_RST;
      end
    end
  end

endmodule

//--- hw/pbd_cycctr.sv
`timescale 1ns/10ps
// Down-counter that holds an instruction busy for its nominal cycles.
module pbd_cycctr
  import pbd_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Load a new count; hold freezes counting during stalls.
  input  wire logic       load,
  input  wire logic [5:0] count,
  input  wire logic       hold,
  // Count has reached its last cycle.
  output logic            last
);
  import pbd_pkg::*;

  logic [5:0] cnt_reg;

  // The take cycle is the first of the count, so one less is loaded and one marks the last cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= PBD_CYC_ZERO;
    end else if (load) begin
      cnt_reg <= (count > PBD_CYC_ZERO) ? count - PBD_CYC_ONE : PBD_CYC_ZERO;
    end else if (!hold && cnt_reg != PBD_CYC_ZERO) begin
      cnt_reg <= cnt_reg - PBD_CYC_ONE;
    end
  end

  assign last = (cnt_reg == PBD_CYC_ONE) && !hold;

endmodule

//--- sim/pbd_fetch_model.sv
`timescale 1ns/10ps
// ****
// Fetch unit stand-in: refills the queue some cycles after a jump.
// ****
module pbd_fetch_model #(
  parameter int REFILL_DLY = 3
) (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rstn,
  // Refill handshake with the decoder.
  input  wire logic flow_change,
  output logic      fetch_refilled
);
  logic [3:0] wait_reg;

  // A slow refill makes the gap cycles after a jump visible at the ports.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg       <= 4'h0;
      fetch_refilled <= 1'b0;
    end else begin
      fetch_refilled <= 1'b0;
      if (!flow_change || fetch_refilled) begin
        wait_reg <= 4'h0;
      end else if (wait_reg == 4'(REFILL_DLY)) begin
        fetch_refilled <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

//--- sim/pbd_decoder_properties.sv
`timescale 1ns/10ps
// ****
// Port checker for the decoder.
// ****
module pbd_decoder_chk
  import pbd_pkg::*;
(
  // Clock and reset.
  input wire logic             core_clk,
  input wire logic             rstn,
  // Fetch side.
  input wire logic             fetch_valid,
  input wire logic [7:0]       fetch_byte,
  input wire logic             fetch_ready,
  input wire logic             read_data_pending,
  // Dispatch and trap side.
  input wire logic             dispatch,
  input wire pbd_pkg::pbd_fn_t prim_fn,
  input wire logic             secondary,
  input wire logic [31:0]      operand_out,
  input wire logic             done,
  input wire logic             free_ram_push,
  input wire logic             illegal,
  input wire logic [3:0]       err_code
);
  logic       take;
  logic [3:0] fn;
  logic       pfx;
  logic       pfx_q;

  // Byte accepted this cycle and its function field.
  assign take = fetch_valid && fetch_ready;
  assign fn   = fetch_byte[7:4];
  assign pfx  = fn == 4'h2 || fn == 4'h6;

  // Tracks prefix nibbles held over, since only without them is a short operand exact.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pfx_q <= 1'b0;
    end else if (take) begin
      pfx_q <= pfx;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_prefix_silent: assert property (take && pfx |=> !dispatch && !illegal)
    else $error("prefix byte produced a dispatch");
  a_primary_dispatch: assert property (take && !pfx && fn != 4'hf |=> dispatch && prim_fn == $past(fn))
    else $error("primary byte dispatched wrongly");
  a_short_operand: assert property (take && !pfx_q && !pfx && fn != 4'hf
    |=> operand_out == {24'h0, $past(fetch_byte) & 8'h0f})
    else $error("single byte operand wrong");
  a_operate_flag: assert property (dispatch |-> secondary == (prim_fn == PBD_FN_OPERATE))
    else $error("secondary flag disagrees with function");
  a_illegal_code: assert property (illegal |-> err_code == PBD_ERR_ILLEGAL && !dispatch)
    else $error("illegal flag without proper code");
  a_wait_read: assert property (read_data_pending |-> !fetch_ready)
    else $error("byte accepted while read data pending");
  a_jump_time: assert property (take && fn == 4'h0 |-> !done ##1 (!done) [*5] ##1 done)
    else $error("jump length wrong");
  a_call_time: assert property (take && fn == 4'h9 |-> (!done) [*7] ##1 done)
    else $error("call length wrong");
  a_free_ram: assert property (free_ram_push |-> dispatch && operand_out == PBD_OP_FREERAM)
    else $error("free memory push without its code");

  c_prefix_take: cover property (take && pfx);
  c_illegal: cover property (illegal);
  c_free_ram: cover property (free_ram_push);
endmodule

bind pbd_decoder pbd_decoder_chk u_pbd_decoder_chk (.*);

//--- sim/pbd_decoder_tb.sv
`timescale 1ns/10ps
module pbd_decoder_tb;
  import pbd_pkg::*;
  // ****
  // Signals and table rows.
  // ****
  typedef struct {
    int          n;
    logic [23:0] b;
    logic        bz;
    logic [3:0]  fn;
    logic [31:0] op;
    logic        sec;
    logic [7:0]  tg;
    int          cy;
  } pbd_row_t;
  logic        core_clk, rstn, fetch_valid, fetch_ready, flow_change, fetch_refilled;
  logic        mem_issue, mem_done, mem_other_busy, read_data_pending, branch_zero;
  logic        trap_enabled, trap_raised, dispatch, secondary, busy, done, free_ram_push, illegal;
  logic [7:0]  fetch_byte, feature_tags;
  logic [5:0]  var_cycles;
  logic [3:0]  err_code;
  logic [31:0] operand_out;
  pbd_fn_t     prim_fn;
  int          miscompares = 0;
  int          check_count = 0;
  logic        d0;
  int          cnt;
  // Bytes, branch level, function, operand, operate flag, tags, cycles (0: not checked).
  pbd_row_t rows [27] = '{
    '{1, 24'h43, 0, 4, 3, 0, 0, 1}, '{2, 24'h2345, 0, 4, 32'h35, 0, 0, 1},
    '{3, 24'h292847, 0, 4, 32'h987, 0, 0, 1}, '{2, 24'h6141, 0, 4, 32'hffffffe1, 0, 0, 1},
    '{1, 24'h05, 0, 0, 5, 0, 8'hc0, 7}, '{1, 24'h13, 0, 1, 3, 0, 0, 1},
    '{1, 24'h34, 0, 3, 4, 0, 0, 1}, '{1, 24'h52, 0, 5, 2, 0, 0, 1},
    '{1, 24'h71, 0, 7, 1, 0, 0, 1}, '{1, 24'h81, 0, 8, 1, 0, 8'h08, 0},
    '{1, 24'h91, 0, 9, 1, 0, 0, 8}, '{1, 24'ha3, 0, 10, 3, 0, 0, 1},
    '{1, 24'ha3, 1, 10, 3, 0, 0, 7}, '{1, 24'hb2, 0, 11, 2, 0, 0, 2},
    '{1, 24'hc1, 0, 12, 1, 0, 0, 1}, '{1, 24'hd1, 0, 13, 1, 0, 0, 1},
    '{1, 24'he1, 0, 14, 1, 0, 0, 2}, '{2, 24'h24f6, 0, 15, 32'h46, 1, 0, 1},
    '{1, 24'hf5, 0, 15, 5, 1, 8'h28, 2}, '{2, 24'h23fe, 0, 15, 32'h3e, 1, 0, 3},
    '{2, 24'h23fd, 0, 15, 32'h3d, 1, 0, 3}, '{2, 24'h21f8, 0, 15, 32'h18, 1, 0, 1},
    '{2, 24'h25f0, 0, 15, 32'h50, 1, 0, 1}, '{2, 24'h21fc, 0, 15, 32'h1c, 1, 0, 1},
    '{2, 24'h21f7, 0, 15, 32'h17, 1, 0, 1}, '{2, 24'h27fe, 0, 15, 32'h7e, 1, 0, 1},
    '{2, 24'h22fc, 0, 15, 32'h2c, 1, 8'h28, 10}};

  pbd_decoder u_pbd_decoder (.*);
  pbd_fetch_model u_pbd_fetch_model (.*);

  // ****
  // Tasks.
  // ****
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Ready is combinational, so it is judged at the falling edge once settled.
  task automatic wait_ready();
    int k;
    for (k = 0; k < 100; k++) begin
      @(negedge core_clk);
      if (fetch_ready === 1'b1) break;
    end
    if (k == 100) begin
      miscompares++;
      finish_test();
    end
  endtask

  // Holds the byte until the edge that takes it.
  task automatic send(logic [7:0] b);
    fetch_valid <= 1'b1;
    fetch_byte  <= b;
    wait_ready();
    d0 = done;
    @(posedge core_clk);
  endtask

  task automatic run_row(pbd_row_t r);
    branch_zero <= r.bz;
    for (int k = 0; k < r.n; k++) send(r.b[8*(r.n-1-k) +: 8]);
    fetch_valid <= 1'b0;
    @(negedge core_clk);
    chk("dispatch", 1, dispatch);
    chk("prim_fn", r.fn, prim_fn);
    chk("operand_out", r.op, operand_out);
    chk("secondary", r.sec, secondary);
    chk("feature_tags", r.tg, feature_tags);
    chk("free_ram_push", r.sec && r.op == PBD_OP_FREERAM, free_ram_push);
    cnt = d0 ? 1 : 2;
    while (!d0 && done !== 1'b1 && cnt < 60) begin
      @(negedge core_clk);
      cnt++;
    end
    if (cnt == 60) miscompares++;
    if (r.cy != 0) chk("cycles", r.cy, cnt);
    @(negedge core_clk);
    chk("flow_change", r.fn == 0 || r.fn == 9 || (r.fn == 10 && r.bz), flow_change);
    wait_ready();
    @(posedge core_clk);
  endtask

  // ****
  // Stimulus.
  // ****
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    {rstn, fetch_valid, fetch_byte, mem_issue, mem_done, mem_other_busy} = '0;
    {read_data_pending, branch_zero, trap_enabled, trap_raised} = '0;
    var_cycles = 6'h0a;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk("dispatch", 0, dispatch);
    chk("operand_out", 0, operand_out);
    @(posedge core_clk);
    foreach (rows[i]) run_row(rows[i]);
    // Unknown operate code, first with the trap handler on, then off.
    for (int t = 1; t >= 0; t--) begin
      trap_enabled <= t[0];
      send(8'h2f);
      send(8'h2f);
      send(8'hff);
      fetch_valid <= 1'b0;
      @(negedge core_clk);
      chk("illegal", t, illegal);
      chk("err_code", t, err_code);
      chk("dispatch", 0, dispatch);
      wait_ready();
      @(posedge core_clk);
    end
    // A pending read holds the next byte back until its data lands.
    read_data_pending <= 1'b1;
    fetch_valid       <= 1'b1;
    fetch_byte        <= 8'h43;
    repeat (3) begin
      @(negedge core_clk);
      chk("fetch_ready", 0, fetch_ready);
    end
    @(posedge core_clk);
    read_data_pending <= 1'b0;
    send(8'h43);
    fetch_valid <= 1'b0;
    @(negedge core_clk);
    chk("dispatch", 1, dispatch);
    // Another memory user holds a store back; the count waits for it.
    @(posedge core_clk);
    mem_other_busy <= 1'b1;
    send(8'he1);
    fetch_valid <= 1'b0;
    repeat (3) begin
      @(negedge core_clk);
      chk("done", 0, done);
      chk("busy", 1, busy);
    end
    @(posedge core_clk);
    mem_other_busy <= 1'b0;
    @(negedge core_clk);
    chk("done", 1, done);
    // Two operations in flight hold the next store until one completes.
    @(posedge core_clk);
    mem_issue <= 1'b1;
    repeat (2) @(posedge core_clk);
    mem_issue <= 1'b0;
    send(8'he1);
    fetch_valid <= 1'b0;
    @(negedge core_clk);
    chk("done", 0, done);
    @(posedge core_clk);
    mem_done <= 1'b1;
    @(posedge core_clk);
    mem_done <= 1'b0;
    @(negedge core_clk);
    chk("done", 1, done);
    finish_test();
  end
endmodule
